// >>> verilog/cdd_pkg.sv
// Package of constants and types shared by the card data DMA engine files
package cdd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_BASE_ADDR = 8'h00;
    localparam logic [7:0] OFF_TRANSFER_LENGTH = 8'h04;
    localparam logic [7:0] OFF_DMA_CONTROL = 8'h08;
    localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h0C;
    localparam logic [7:0] OFF_BUSY_START_STATUS = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_SOFT_RESET_BIT = 24;
    localparam int CTL_IRQ_EN_BIT = 16;
    localparam int CTL_HOLD_MODE_BIT = 10;
    localparam int CTL_WIDTH16_BIT = 9;
    localparam int CTL_DIR_BIT = 8;
    localparam int STAT_IRQ_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_BASE_ADDR = 32'h0000_0000;
    localparam logic [31:0] RST_TRANSFER_LENGTH = 32'h0000_0000;
    localparam logic [31:0] RST_DMA_CONTROL = 32'h0000_0000;

    // ------------------------------------------------------------------
    // FIFO shape and beat sizes
    // ------------------------------------------------------------------
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_PTR_W = 2;
    localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_HALF = 32'h0000_0002;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_DRAIN = 3'b100
    } cdd_state_e;

    typedef struct packed {
        logic irq_en;
        logic hold_mode;
        logic width16;
        logic dir_to_card;
    } cdd_ctrl_s;

    typedef struct packed {
        logic req;
        logic write;
        logic size16;
        logic [31:0] addr;
        logic [15:0] wdata;
    } cdd_mem_req_s;

endpackage : cdd_pkg

// >>> verilog/cdd_fifo.sv
// Small beat FIFO between the card data port and the memory side
`timescale 1ns/1ns
module cdd_fifo (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    input wire logic clr,
    // Fill side
    input wire logic push,
    input wire logic [cdd_pkg::FIFO_WIDTH-1:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [cdd_pkg::FIFO_WIDTH-1:0] head,
    // Status
    output logic empty,
    output logic full
);

    logic [cdd_pkg::FIFO_WIDTH-1:0] mem_q [cdd_pkg::FIFO_DEPTH];
    logic [cdd_pkg::FIFO_PTR_W-1:0] wr_ptr_q;
    logic [cdd_pkg::FIFO_PTR_W-1:0] rd_ptr_q;
    logic [2:0] count_q;
    logic do_push;
    logic do_pop;

    // Pushes when full and pops when empty are dropped
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign empty = (count_q == 3'h0);
    assign full = (count_q == cdd_pkg::FIFO_FULL_COUNT);
    assign head = mem_q[rd_ptr_q];

    // Storage, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (ce && do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (reset || (ce && clr)) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= 3'h0;
        end else if (ce) begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 2'h1;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 2'h1;
            end
            case ({do_push, do_pop})
                2'b10: count_q <= count_q + 3'h1;
                2'b01: count_q <= count_q - 3'h1;
                default: count_q <= count_q;
            endcase
        end
    end

endmodule : cdd_fifo

// >>> verilog/cdd_dma.sv
// Single-channel card data DMA engine with register port, memory port and card FIFO port
//
// Operation
// [RULE_01] Writing transfer length sets the byte count of the next transaction.
// [RULE_02] Length reads remaining count while busy, programmed count while idle.
// [RULE_03] Control bit 24 written one resets the engine and clears itself.
// [RULE_04] Control bit 16 enables the completion interrupt.
// [RULE_05] Bit 10 clear: empty and full always follow the FIFO.
// [RULE_06] Bit 10 set: idle empty/full follow direction, busy they follow FIFO.
// [RULE_07] Control bit 9 picks 8-bit or 16-bit controller data path.
// [RULE_08] Control bit 8 picks card-to-memory (0) or memory-to-card (1).
// [RULE_09] Interrupt asserts when status bit 16 and enable set; write one clears.
// [RULE_10] Setting busy bit starts transfer; reads one while running, clears at end.
// [RULE_11] Base address takes start address; reads current address while busy.
// [RULE_12] Count reaching zero sets interrupt status and returns to idle; memory-to-card waits first for the FIFO to drain.
// [RULE_13] Each beat advances address and decrements count by bytes moved.
`timescale 1ns/1ns
module cdd_dma (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Memory port
    output cdd_pkg::cdd_mem_req_s mem_out,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // Card data port
    input wire logic card_push,
    input wire logic [15:0] card_push_data,
    input wire logic card_pop,
    output logic [15:0] card_pop_data,
    output logic data_empty,
    output logic data_full,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cdd_pkg::cdd_state_e state_q;
    cdd_pkg::cdd_ctrl_s ctrl_q;
    cdd_pkg::cdd_mem_req_s mem_q;
    logic [31:0] base_q;
    logic [31:0] length_q;
    logic [31:0] cur_addr_q;
    logic [31:0] remain_q;
    logic soft_rst_q;
    logic irq_stat_q;
    logic irq_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic empty_q;
    logic full_q;
    logic [15:0] pop_data_q;
    logic busy;
    logic eng_rst;
    logic wr_base;
    logic wr_len;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_start;
    logic issue;
    logic beat_done;
    logic done;
    logic [31:0] step;
    logic [31:0] ack_step;
    logic fifo_push;
    logic fifo_pop;
    logic [15:0] fifo_push_data;
    logic [15:0] fifo_head;
    logic fifo_empty;
    logic fifo_full;

    // ------------------------------------------------------------------
    // Decode and engine strobes
    // ------------------------------------------------------------------
    // Write strobes per register
    assign wr_base = ce && reg_we && (reg_addr == cdd_pkg::OFF_BASE_ADDR);
    assign wr_len = ce && reg_we && (reg_addr == cdd_pkg::OFF_TRANSFER_LENGTH);
    assign wr_ctrl = ce && reg_we && (reg_addr == cdd_pkg::OFF_DMA_CONTROL);
    assign wr_stat = ce && reg_we && (reg_addr == cdd_pkg::OFF_INTERRUPT_STATUS);
    assign wr_start = ce && reg_we && (reg_addr == cdd_pkg::OFF_BUSY_START_STATUS)
        && reg_wdata[cdd_pkg::STAT_BUSY_BIT];
    assign busy = (state_q != cdd_pkg::ST_IDLE);
    assign eng_rst = reset || soft_rst_q;

    // [RULE_07] width picks beat size
    // Odd last byte on the 16-bit path goes out as a single byte
    assign step = (ctrl_q.width16 && (remain_q != cdd_pkg::STEP_BYTE))
        ? cdd_pkg::STEP_HALF : cdd_pkg::STEP_BYTE;
    assign ack_step = mem_q.size16 ? cdd_pkg::STEP_HALF : cdd_pkg::STEP_BYTE;

    // [RULE_08] direction gates issue
    // Card-to-memory needs data waiting; memory-to-card needs FIFO room
    assign issue = ce && (state_q == cdd_pkg::ST_RUN) && !mem_q.req
        && (remain_q != 32'h0)
        && (ctrl_q.dir_to_card ? !fifo_full : !fifo_empty);
    assign beat_done = ce && (state_q == cdd_pkg::ST_RUN) && mem_q.req && mem_ack;

    // [RULE_12] completion detect
    // Memory-to-card also waits for the card to drain the FIFO
    assign done = ce && (((state_q == cdd_pkg::ST_RUN) && !mem_q.req
        && (remain_q == 32'h0) && !ctrl_q.dir_to_card)
        || ((state_q == cdd_pkg::ST_DRAIN) && fifo_empty));

    // FIFO steering by direction
    assign fifo_push = ctrl_q.dir_to_card ? (beat_done && !mem_q.write) : card_push;
    assign fifo_push_data = ctrl_q.dir_to_card ? mem_rdata : card_push_data;
    assign fifo_pop = ctrl_q.dir_to_card ? card_pop : (issue && !ctrl_q.dir_to_card);

    // ------------------------------------------------------------------
    // Beat FIFO
    // ------------------------------------------------------------------
    cdd_fifo u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .clr(soft_rst_q),
        .push(fifo_push),
        .push_data(fifo_push_data),
        .pop(fifo_pop),
        .head(fifo_head),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Base, length and control fields
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            base_q <= cdd_pkg::RST_BASE_ADDR;
            length_q <= cdd_pkg::RST_TRANSFER_LENGTH;
            ctrl_q <= '0;
        end else begin
            // [RULE_11] base address write
            if (wr_base) begin
                base_q <= reg_wdata;
            end
            // [RULE_01] length write
            if (wr_len) begin
                length_q <= reg_wdata;
            end
            // [RULE_04] interrupt enable store
            if (wr_ctrl) begin
                ctrl_q.irq_en <= reg_wdata[cdd_pkg::CTL_IRQ_EN_BIT];
                ctrl_q.hold_mode <= reg_wdata[cdd_pkg::CTL_HOLD_MODE_BIT];
                ctrl_q.width16 <= reg_wdata[cdd_pkg::CTL_WIDTH16_BIT];
                ctrl_q.dir_to_card <= reg_wdata[cdd_pkg::CTL_DIR_BIT];
            end
        end
    end

    // [RULE_03] self-clearing soft reset
    // Held one enabled cycle; clears engine and FIFO, keeps configuration
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            soft_rst_q <= 1'b0;
        end else if (ce) begin
            soft_rst_q <= wr_ctrl && reg_wdata[cdd_pkg::CTL_SOFT_RESET_BIT];
        end
    end

    // [RULE_09] sticky status, write one clears
    // A completion in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys) begin
        if (eng_rst) begin
            irq_stat_q <= 1'b0;
        end else if (ce) begin
            irq_stat_q <= done || (irq_stat_q
                && !(wr_stat && reg_wdata[cdd_pkg::STAT_IRQ_BIT]));
        end
    end

    // [RULE_04] enable gates interrupt
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= irq_stat_q && ctrl_q.irq_en;
        end
    end

    // Read mux; unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 32'h0;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            rvalid_q <= reg_re;
            if (reg_re) begin
                case (reg_addr)
                    // [RULE_11] address readback
                    cdd_pkg::OFF_BASE_ADDR: rdata_q <= busy ? cur_addr_q : base_q;
                    // [RULE_02] count readback
                    cdd_pkg::OFF_TRANSFER_LENGTH: rdata_q <= busy ? remain_q : length_q;
                    cdd_pkg::OFF_DMA_CONTROL: begin
                        rdata_q <= 32'h0;
                        rdata_q[cdd_pkg::CTL_SOFT_RESET_BIT] <= soft_rst_q;
                        rdata_q[cdd_pkg::CTL_IRQ_EN_BIT] <= ctrl_q.irq_en;
                        rdata_q[cdd_pkg::CTL_HOLD_MODE_BIT] <= ctrl_q.hold_mode;
                        rdata_q[cdd_pkg::CTL_WIDTH16_BIT] <= ctrl_q.width16;
                        rdata_q[cdd_pkg::CTL_DIR_BIT] <= ctrl_q.dir_to_card;
                    end
                    cdd_pkg::OFF_INTERRUPT_STATUS: begin
                        rdata_q <= 32'h0;
                        rdata_q[cdd_pkg::STAT_IRQ_BIT] <= irq_stat_q;
                    end
                    // [RULE_10] busy readback
                    cdd_pkg::OFF_BUSY_START_STATUS: begin
                        rdata_q <= 32'h0;
                        rdata_q[cdd_pkg::STAT_BUSY_BIT] <= busy;
                    end
                    default: rdata_q <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------
    // State, working address and count, memory request
    always_ff @(posedge clk_sys) begin
        if (eng_rst) begin
            state_q <= cdd_pkg::ST_IDLE;
            cur_addr_q <= 32'h0;
            remain_q <= 32'h0;
            mem_q <= '0;
        end else if (ce) begin
            case (state_q)
                cdd_pkg::ST_IDLE: begin
                    // [RULE_10] start on busy write
                    if (wr_start) begin
                        cur_addr_q <= base_q;
                        remain_q <= length_q;
                        state_q <= cdd_pkg::ST_RUN;
                    end
                end
                cdd_pkg::ST_RUN: begin
                    if (beat_done) begin
                        // [RULE_13] advance per beat
                        mem_q.req <= 1'b0;
                        cur_addr_q <= cur_addr_q + ack_step;
                        remain_q <= remain_q - ack_step;
                    end else if (issue) begin
                        mem_q.req <= 1'b1;
                        mem_q.write <= !ctrl_q.dir_to_card;
                        mem_q.size16 <= (step == cdd_pkg::STEP_HALF);
                        mem_q.addr <= cur_addr_q;
                        mem_q.wdata <= fifo_head;
                    end else if (!mem_q.req && (remain_q == 32'h0)) begin
                        // [RULE_12] at zero: back to idle, or to drain when memory-to-card
                        state_q <= ctrl_q.dir_to_card ? cdd_pkg::ST_DRAIN : cdd_pkg::ST_IDLE;
                    end
                end
                cdd_pkg::ST_DRAIN: begin
                    if (fifo_empty) begin
                        state_q <= cdd_pkg::ST_IDLE;
                    end
                end
                default: state_q <= cdd_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Card side outputs
    // ------------------------------------------------------------------
    // [RULE_06] hold mode idle levels
    // [RULE_05] natural mode follows FIFO
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            empty_q <= 1'b1;
            full_q <= 1'b0;
            pop_data_q <= 16'h0;
        end else if (ce) begin
            if (busy || !ctrl_q.hold_mode) begin
                empty_q <= fifo_empty;
                full_q <= fifo_full;
            end else begin
                empty_q <= ctrl_q.dir_to_card;
                full_q <= !ctrl_q.dir_to_card;
            end
            if (card_pop && ctrl_q.dir_to_card && !fifo_empty) begin
                pop_data_q <= fifo_head;
            end
        end
    end

    // Output assignments, all from flip-flops
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign mem_out = mem_q;
    assign card_pop_data = pop_data_q;
    assign data_empty = empty_q;
    assign data_full = full_q;
    assign irq = irq_q;

endmodule : cdd_dma

// >>> sim/cdd_dma_sva.sv
// Port-level assertion checker for the card data DMA engine
`timescale 1ns/1ns
module cdd_dma_sva (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    // Memory, card and interrupt
    input wire cdd_pkg::cdd_mem_req_s mem_out,
    input wire logic mem_ack,
    input wire logic data_empty,
    input wire logic data_full,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic soft_q;
    logic exp_v_q;
    logic [31:0] exp_a_q;
    wire ctl_wr = reg_we && ce && reg_addr == cdd_pkg::OFF_DMA_CONTROL;

    // ------------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------------
    // Soft reset pulse seen on the register port
    always_ff @(posedge clk_sys) begin
        soft_q <= !reset && ctl_wr && reg_wdata[cdd_pkg::CTL_SOFT_RESET_BIT];
    end
    // Next expected address; forgotten on a new start or soft reset
    always_ff @(posedge clk_sys) begin
        if (reset || soft_q || (reg_we && reg_addr == cdd_pkg::OFF_BUSY_START_STATUS)) begin
            exp_v_q <= 1'b0;
        end else if (mem_out.req && mem_ack) begin
            exp_v_q <= 1'b1;
            exp_a_q <= mem_out.addr + (mem_out.size16 ? 32'h2 : 32'h1);
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_reset_vals;
        $fell(reset) |-> data_empty && !data_full && !irq && !mem_out.req && !reg_rvalid;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
    property p_read_answer;
        ce |=> reg_rvalid == $past(reg_re);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_unmapped;
        reg_re && ce && reg_addr >= 8'h14 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_req_hold;
        mem_out.req && !mem_ack && !soft_q |=> mem_out.req && $stable(mem_out);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
    property p_req_drop;
        mem_out.req && mem_ack |=> !mem_out.req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    property p_addr_step;
        $rose(mem_out.req) && exp_v_q |-> mem_out.addr == exp_a_q;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step wrong");
    property p_soft_drop;
        ctl_wr && reg_wdata[cdd_pkg::CTL_SOFT_RESET_BIT] |=> ##1 !mem_out.req;
    endproperty
    a_soft_drop: assert property (p_soft_drop) else $error("soft reset kept request");
    property p_irq_off;
        ctl_wr && !reg_wdata[cdd_pkg::CTL_IRQ_EN_BIT] |=> ##1 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

    // Main scenarios reached
    c_write_beat: cover property (mem_out.req && mem_ack && mem_out.write);
    c_read_beat: cover property (mem_out.req && mem_ack && !mem_out.write);
    c_irq: cover property ($rose(irq));
endmodule : cdd_dma_sva

bind cdd_dma cdd_dma_sva u_sva (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_we(reg_we), .reg_re(reg_re),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mem_out(mem_out), .mem_ack(mem_ack),
    .data_empty(data_empty), .data_full(data_full), .irq(irq)
);

// >>> sim/cdd_mem_model.sv
// Memory-side partner model answering the engine's memory requests
`timescale 1ns/1ns
module cdd_mem_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Request in, answer out
    input wire cdd_pkg::cdd_mem_req_s mem_out,
    input wire logic [3:0] slow,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [7:0] mem [logic [31:0]];
    logic [3:0] wait_q;

    function automatic logic [7:0] rdb(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction : rdb

    // Ack after slow cycles; data churns outside the ack cycle so stale reads show
    always @(posedge clk_sys) begin
        if (reset) begin
            mem_ack <= 1'b0;
            wait_q <= 4'h0;
            mem_rdata <= 16'hA5A5;
        end else if (mem_out.req && !mem_ack && wait_q >= slow) begin
            mem_ack <= 1'b1;
            wait_q <= 4'h0;
            if (mem_out.write) begin
                mem[mem_out.addr] = mem_out.wdata[7:0];
                if (mem_out.size16) begin
                    mem[mem_out.addr + 32'h1] = mem_out.wdata[15:8];
                end
            end else begin
                mem_rdata <= {rdb(mem_out.addr + 32'h1), rdb(mem_out.addr)};
            end
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q <= mem_out.req ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : cdd_mem_model

// >>> sim/tb_card_data_dma_engine.sv
// Register-level testbench for the card data DMA engine
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_card_data_dma_engine;
    logic clk_sys, reset, ce, reg_we, reg_re, reg_rvalid, mem_ack, irq;
    logic card_push, card_pop, data_empty, data_full;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_v;
    logic [15:0] mem_rdata, card_push_data, card_pop_data;
    logic [3:0] slow;
    cdd_pkg::cdd_mem_req_s mem_out;
    int num_errors = 0;
    int n_checks = 0;

    cdd_dma u_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_we(reg_we),
        .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .card_push(card_push), .card_push_data(card_push_data), .card_pop(card_pop),
        .card_pop_data(card_pop_data), .data_empty(data_empty), .data_full(data_full),
        .irq(irq));
    cdd_mem_model u_mem (.clk_sys(clk_sys), .reset(reset), .mem_out(mem_out), .slow(slow),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ------------------------------------------------------------------
    // Bus and card tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask : wr
    // Answer is registered, so look one step after the taking edge
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1 rd_v = reg_rdata;
        `CHK(rd_v, e)
    endtask : rchk
    task automatic wait_idle;
        for (int i = 0; i < 100; i++) begin
            repeat (4) @(posedge clk_sys);
            if (u_dut.reg_rdata[0] === 1'b0 && reg_addr == 8'h10 && i > 0) break;
            @(posedge clk_sys);
            reg_re <= 1'b1;
            reg_addr <= cdd_pkg::OFF_BUSY_START_STATUS;
            @(posedge clk_sys);
            reg_re <= 1'b0;
        end
        rchk(cdd_pkg::OFF_BUSY_START_STATUS, 32'h0);
    endtask : wait_idle
    task automatic push(input logic [15:0] d);
        @(posedge clk_sys);
        card_push <= 1'b1;
        card_push_data <= d;
        @(posedge clk_sys);
        card_push <= 1'b0;
    endtask : push
    // Flags lag the FIFO by a cycle, so let two edges pass before trusting them
    task automatic pop_chk(input logic [15:0] e);
        repeat (2) @(negedge clk_sys);
        for (int i = 0; i < 100 && data_empty !== 1'b0; i++) @(negedge clk_sys);
        @(posedge clk_sys);
        card_pop <= 1'b1;
        @(posedge clk_sys);
        card_pop <= 1'b0;
        #1 `CHK(card_pop_data, e)
    endtask : pop_chk
    task automatic start(input logic [31:0] b, input logic [31:0] n, input logic [31:0] c);
        wr(cdd_pkg::OFF_BASE_ADDR, b);
        wr(cdd_pkg::OFF_TRANSFER_LENGTH, n);
        wr(cdd_pkg::OFF_DMA_CONTROL, c);
        wr(cdd_pkg::OFF_BUSY_START_STATUS, 32'h1);
    endtask : start
    task automatic summarize;
        if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Whole sequence needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        {reg_we, reg_re, card_push, card_pop} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        card_push_data = 16'h0;
        slow = 4'hF;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        // Reset values, unmapped place ignored
        for (int k = 0; k < 6; k++) rchk(8'(4 * k), 32'h0);
        wr(8'h20, 32'hFFFF_FFFF);
        rchk(8'h20, 32'h0);
        `CHK({data_empty, data_full}, 2'b10)
        // Idle flags in hold mode follow direction
        for (int d = 0; d < 2; d++) begin
            wr(cdd_pkg::OFF_DMA_CONTROL, 32'h400 | (32'(d) << 8));
            repeat (3) @(posedge clk_sys);
            #1 `CHK({data_empty, data_full}, d ? 2'b10 : 2'b01)
        end
        // Card to memory, 8-bit, slow memory, interrupt on
        start(32'h100, 32'h3, 32'h1_0000);
        rchk(cdd_pkg::OFF_TRANSFER_LENGTH, 32'h3);
        rchk(cdd_pkg::OFF_BASE_ADDR, 32'h100);
        rchk(cdd_pkg::OFF_BUSY_START_STATUS, 32'h1);
        for (int k = 0; k < 3; k++) push({8'hEE, 8'(8'h11 * (k + 1))});
        wait_idle();
        for (int k = 0; k < 3; k++) `CHK(u_mem.mem[32'h100 + k], 8'(8'h11 * (k + 1)))
        rchk(cdd_pkg::OFF_TRANSFER_LENGTH, 32'h3);
        rchk(cdd_pkg::OFF_BASE_ADDR, 32'h100);
        rchk(cdd_pkg::OFF_INTERRUPT_STATUS, 32'h1_0000);
        `CHK(irq, 1'b1)
        wr(cdd_pkg::OFF_INTERRUPT_STATUS, 32'h1_0000);
        rchk(cdd_pkg::OFF_INTERRUPT_STATUS, 32'h0);
        `CHK(irq, 1'b0)
        // 16-bit, odd length, fast memory, interrupt off
        slow <= 4'h0;
        start(32'h200, 32'h5, 32'h200);
        for (int k = 0; k < 3; k++) push({8'(8'h11 * (2 * k + 2)), 8'(8'h11 * (2 * k + 1))});
        wait_idle();
        for (int k = 0; k < 5; k++) `CHK(u_mem.mem[32'h200 + k], 8'(8'h11 * (k + 1)))
        rchk(cdd_pkg::OFF_INTERRUPT_STATUS, 32'h1_0000);
        `CHK(irq, 1'b0)
        wr(cdd_pkg::OFF_INTERRUPT_STATUS, 32'h1_0000);
        // Memory to card, 16-bit
        for (int k = 0; k < 4; k++) u_mem.mem[32'h300 + k] = 8'hA0 + 8'(k);
        slow <= 4'h2;
        start(32'h300, 32'h4, 32'h300);
        pop_chk(16'hA1A0);
        rchk(cdd_pkg::OFF_BUSY_START_STATUS, 32'h1);
        pop_chk(16'hA3A2);
        wait_idle();
        // Soft reset in mid-transfer keeps the fields
        slow <= 4'hF;
        start(32'h400, 32'h8, 32'h1_0000);
        push(16'h0077);
        repeat (3) @(posedge clk_sys);
        wr(cdd_pkg::OFF_DMA_CONTROL, 32'h0101_0000);
        rchk(cdd_pkg::OFF_DMA_CONTROL, 32'h1_0000);
        rchk(cdd_pkg::OFF_BUSY_START_STATUS, 32'h0);
        rchk(cdd_pkg::OFF_TRANSFER_LENGTH, 32'h8);
        rchk(cdd_pkg::OFF_INTERRUPT_STATUS, 32'h0);
        `CHK({data_empty, irq}, 2'b10)
        // Frozen while ce is low
        ce <= 1'b0;
        wr(cdd_pkg::OFF_BASE_ADDR, 32'h0);
        ce <= 1'b1;
        rchk(cdd_pkg::OFF_BASE_ADDR, 32'h400);
        summarize();
    end
endmodule : tb_card_data_dma_engine
